// ===== calseq_pkg.sv
// calibration mode sequencer: shared constants, register map and types
// assumes a 32-bit axi4-lite register bus and a single 100 MHz clock
package calseq_pkg;

    // ==========================================================
    // register map (word indices; byte address is four times the index)
    localparam int ADDR_W = 8;
    localparam logic [2:0] IDX_MODE = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_ZS_COEF = 3'h2;
    localparam logic [2:0] IDX_FS_COEF = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [2:0] IDX_IRQ_STAT = 3'h5;
    localparam logic [2:0] IDX_IRQ_MASK = 3'h6;

    // ==========================================================
    // mode register fields
    localparam int MODE_LSB = 0;
    localparam int CHAN_LSB = 3;
    localparam int GAIN_LSB = 6;
    localparam int CTRL_W = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF = 3'h1;
    localparam logic [2:0] MODE_BG = 3'h5;
    localparam logic [2:0] MODE_ZS_SELF = 3'h6;
    localparam logic [2:0] MODE_FS_SELF = 3'h7;

    // ==========================================================
    // sequencing and event constants
    localparam int WORD_W = 24;
    localparam logic [2:0] BG_ZERO_CYCLES = 3'h5;
    localparam logic [1:0] STEP_RST = 2'h0;
    localparam logic [WORD_W-1:0] COEF_RST = 24'h000000;
    localparam int EV_WORD = 0;
    localparam int EV_SELFCAL = 1;
    localparam int EV_BGCOEF = 2;
    localparam int NUM_EV = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {KIND_CONV, KIND_ZERO, KIND_FULL} calseq_kind_t;

endpackage : calseq_pkg

// ===== calseq_top.sv
// calibration mode sequencer: chooses conversion or calibration cycles per the mode field
// assumes a filter core on the same clock that runs one cycle per start pulse and returns a word
// Overview of operation
// - mode code 101 enters background calibration on the selected channel
// - background mode keeps doing zero-scale calibrations at selected gain, inputs shorted
// - background mode interleaves calibration cycles so output word rate drops sixfold
// - background zero-scale coefficient register updates itself as calibration cycles finish
// - mode code 110 runs zero-scale self-calibration, selected channel and gain, inputs shorted
// - zero-scale self-calibration is one step, then mode bits clear to 000
// - ready goes high at zero-scale calibration start, low when new word is stored
// - mode code 111 runs full-scale self-calibration on reference divided by gain
// - full-scale self-calibration is one step, then mode bits clear to 000
// - ready rises at full-scale calibration start, falls when fresh word is stored
// - mode code 001 runs zero-scale then full-scale calibration, then clears mode bits
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module calseq_top
    import calseq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic cycle_start,
    output calseq_kind_t cycle_kind,
    output logic inputs_shorted,
    output logic ref_div_gain,
    output logic [2:0] channel_sel,
    output logic [2:0] gain_code,
    input wire logic cycle_done,
    input wire logic [WORD_W-1:0] cycle_word,
    output logic result_ready_n,
    output logic irq
);

    // ==========================================================
    // address decode, shared by the write and read paths
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = (a[7:5] == 3'h0) && (a[1:0] == 2'h0) && (a[4:2] != 3'h7);
        return {hit, a[4:2]};
    endfunction : reg_sel

    typedef enum logic {ST_ISSUE, ST_WAIT} calseq_state_t;

    calseq_state_t st_q;
    logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [NUM_EV-1:0] irq_mask_q, irq_stat_q, irq_stat_d, ev;
    logic [WORD_W-1:0] zs_coef_q, fs_coef_q, data_q;
    logic [1:0] step_q;
    logic [2:0] bg_cnt_q;
    logic start_q, shorted_q, refdiv_q, ready_n_q, irq_q;
    calseq_kind_t kind_q, kind_d;
    logic hs_aw, hs_w, hs_ar, do_wr, wr_mode, rd_data, rd_stat, done_conv, selfcal_mode;
    logic [3:0] wsel, rsel;
    logic [2:0] mode;

    assign mode = ctrl_q[MODE_LSB +: 3];
    assign hs_aw = s_axi_awvalid && awready_q;
    assign hs_w = s_axi_wvalid && wready_q;
    assign hs_ar = s_axi_arvalid && arready_q;
    assign do_wr = aw_got_q && w_got_q && !bvalid_q;
    assign wsel = reg_sel(awaddr_q);
    assign rsel = reg_sel(s_axi_araddr);
    assign wr_mode = do_wr && wsel[3] && (wsel[2:0] == IDX_MODE);
    assign rd_data = hs_ar && rsel[3] && (rsel[2:0] == IDX_DATA);
    assign rd_stat = hs_ar && rsel[3] && (rsel[2:0] == IDX_IRQ_STAT);
    assign selfcal_mode = (mode == MODE_SELF) || (mode == MODE_ZS_SELF) || (mode == MODE_FS_SELF);
    assign done_conv = (st_q == ST_WAIT) && cycle_done && (kind_q == KIND_CONV);

    // ==========================================================
    // axi4-lite write channel: address and data taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (hs_aw) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_got_q <= 1'b0;
            end
            if (hs_w) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_wr) begin
                w_got_q <= 1'b0;
            end
            // ready stays low while a word is held, so one write at a time
            awready_q <= !(aw_got_q || hs_aw) && !bvalid_q && !do_wr;
            wready_q <= !(w_got_q || hs_w) && !bvalid_q && !do_wr;
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= wsel[3] ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // axi4-lite read channel, one cycle from address to data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            if (hs_ar) begin
                rvalid_q <= 1'b1;
                rresp_q <= rsel[3] ? RESP_OKAY : RESP_SLVERR;
                if (!rsel[3]) begin
                    // unmapped addresses alias a real index, so blank them rather than leak it
                    rdata_q <= 32'h00000000;
                end else begin
                    case (rsel[2:0])
                        IDX_MODE: rdata_q <= {23'h000000, ctrl_q};
                        IDX_STATUS: rdata_q <= {25'h0000000, bg_cnt_q, step_q, (st_q == ST_WAIT), ready_n_q};
                        IDX_ZS_COEF: rdata_q <= {8'h00, zs_coef_q};
                        IDX_FS_COEF: rdata_q <= {8'h00, fs_coef_q};
                        IDX_DATA: rdata_q <= {8'h00, data_q};
                        IDX_IRQ_STAT: rdata_q <= {29'h00000000, irq_stat_q};
                        IDX_IRQ_MASK: rdata_q <= {29'h00000000, irq_mask_q};
                        default: rdata_q <= 32'h00000000;
                    endcase
                end
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
            arready_q <= !rvalid_q && !hs_ar;
        end
    end

    // ==========================================================
    // mode, channel and gain; software write beats the hardware clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            irq_mask_q <= '0;
        end else begin
            if (wr_mode) begin
                if (wstrb_q[0]) ctrl_q[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) ctrl_q[8] <= wdata_q[8];
            end else if (done_conv && selfcal_mode && (step_q != STEP_RST)) begin
                ctrl_q[MODE_LSB +: 3] <= MODE_NORMAL;
            end
            if (do_wr && wsel[3] && (wsel[2:0] == IDX_IRQ_MASK) && wstrb_q[0]) begin
                irq_mask_q <= wdata_q[NUM_EV-1:0];
            end
        end
    end

    // ==========================================================
    // cycle kind for the next filter cycle
    always_comb begin
        kind_d = KIND_CONV;
        case (mode)
            MODE_SELF: kind_d = (step_q == 2'h0) ? KIND_ZERO : (step_q == 2'h1) ? KIND_FULL : KIND_CONV;
            MODE_ZS_SELF: kind_d = (step_q == 2'h0) ? KIND_ZERO : KIND_CONV;
            MODE_FS_SELF: kind_d = (step_q == 2'h0) ? KIND_FULL : KIND_CONV;
            // five zero-scale cycles per word: one word in six cycles
            MODE_BG: kind_d = (bg_cnt_q < BG_ZERO_CYCLES) ? KIND_ZERO : KIND_CONV;
            default: kind_d = KIND_CONV;
        endcase
    end

    // ==========================================================
    // cycle sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_ISSUE;
            start_q <= 1'b0;
            kind_q <= KIND_CONV;
            shorted_q <= 1'b0;
            refdiv_q <= 1'b0;
            step_q <= STEP_RST;
            bg_cnt_q <= 3'h0;
        end else begin
            case (st_q)
                ST_ISSUE: begin
                    start_q <= 1'b1;
                    kind_q <= kind_d;
                    shorted_q <= (kind_d == KIND_ZERO);
                    refdiv_q <= (kind_d == KIND_FULL);
                    st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    start_q <= 1'b0;
                    if (cycle_done) begin
                        st_q <= ST_ISSUE;
                        if (mode == MODE_BG) begin
                            // count zero-scale results only, so the cycle in flight at the mode write is not one
                            bg_cnt_q <= (kind_q == KIND_ZERO) ? bg_cnt_q + 3'h1 : 3'h0;
                        end
                        if (selfcal_mode && kind_q != KIND_CONV) begin
                            step_q <= step_q + 2'h1;
                        end else if (kind_q == KIND_CONV) begin
                            step_q <= STEP_RST;
                        end
                    end
                end
                default: st_q <= ST_ISSUE;
            endcase
            // a new mode starts its sequence from the top
            if (wr_mode) begin
                step_q <= STEP_RST;
                bg_cnt_q <= 3'h0;
            end
        end
    end

    // ==========================================================
    // coefficients, data word and ready indication
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zs_coef_q <= COEF_RST;
            fs_coef_q <= COEF_RST;
            data_q <= COEF_RST;
            ready_n_q <= 1'b1;
        end else begin
            if ((st_q == ST_WAIT) && cycle_done && kind_q == KIND_ZERO) begin
                zs_coef_q <= cycle_word;
            end
            if ((st_q == ST_WAIT) && cycle_done && kind_q == KIND_FULL) begin
                fs_coef_q <= cycle_word;
            end
            if (done_conv) begin
                data_q <= cycle_word;
                ready_n_q <= 1'b0;
            end else if (st_q == ST_ISSUE && selfcal_mode && step_q == STEP_RST) begin
                ready_n_q <= 1'b1;
            end else if (rd_data) begin
                ready_n_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // interrupt status: sticky, cleared by read, a new event wins
    assign ev[EV_WORD] = done_conv;
    assign ev[EV_SELFCAL] = done_conv && selfcal_mode && (step_q != STEP_RST);
    assign ev[EV_BGCOEF] = (st_q == ST_WAIT) && cycle_done && kind_q == KIND_ZERO && mode == MODE_BG;
    for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
        assign irq_stat_d[i] = ev[i] || (irq_stat_q[i] && !rd_stat);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign cycle_start = start_q;
    assign cycle_kind = kind_q;
    assign inputs_shorted = shorted_q;
    assign ref_div_gain = refdiv_q;
    assign channel_sel = ctrl_q[CHAN_LSB +: 3];
    assign gain_code = ctrl_q[GAIN_LSB +: 3];
    assign result_ready_n = ready_n_q;
    assign irq = irq_q;

    // ==========================================================
    // checks
    property p_bg_zero;
        @(posedge clk) disable iff (!rst_n)
        (st_q == ST_ISSUE && mode == MODE_BG && bg_cnt_q < BG_ZERO_CYCLES && !wr_mode)
            |=> (start_q && kind_q == KIND_ZERO && shorted_q);
    endproperty
    a_bg_zero: assert property (p_bg_zero) else $error("background cycle not zero-scale");

    property p_bg_rate;
        @(posedge clk) disable iff (!rst_n)
        (start_q && kind_q == KIND_CONV && mode == MODE_BG && !$past(wr_mode)) |-> (bg_cnt_q == BG_ZERO_CYCLES);
    endproperty
    a_bg_rate: assert property (p_bg_rate) else $error("background word not after five cal cycles");

    property p_bg_coef;
        @(posedge clk) disable iff (!rst_n)
        (st_q == ST_WAIT && cycle_done && kind_q == KIND_ZERO) |=> (zs_coef_q == $past(cycle_word));
    endproperty
    a_bg_coef: assert property (p_bg_coef) else $error("zero-scale coefficient not updated");

    property p_zs_start;
        @(posedge clk) disable iff (!rst_n)
        (st_q == ST_ISSUE && mode == MODE_ZS_SELF && step_q == 2'h0 && !wr_mode)
            |=> (ready_n_q && kind_q == KIND_ZERO && shorted_q);
    endproperty
    a_zs_start: assert property (p_zs_start) else $error("zero-scale self-cal start wrong");

    property p_mode_clear;
        @(posedge clk) disable iff (!rst_n)
        (done_conv && selfcal_mode && step_q != 2'h0 && !wr_mode) |=> (mode == MODE_NORMAL && !ready_n_q);
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("mode bits not cleared");

    property p_fs_start;
        @(posedge clk) disable iff (!rst_n)
        (st_q == ST_ISSUE && mode == MODE_FS_SELF && step_q == 2'h0 && !wr_mode)
            |=> (ready_n_q && refdiv_q && !shorted_q) ##1 (ready_n_q throughout (st_q == ST_WAIT)[*1]);
    endproperty
    a_fs_start: assert property (p_fs_start) else $error("full-scale self-cal start wrong");

    property p_ready_low;
        @(posedge clk) disable iff (!rst_n)
        done_conv |=> (!ready_n_q && data_q == $past(cycle_word));
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready not low with new word");

    property p_self_full;
        @(posedge clk) disable iff (!rst_n)
        (st_q == ST_ISSUE && mode == MODE_SELF && step_q == 2'h1 && !wr_mode) |=> (kind_q == KIND_FULL);
    endproperty
    a_self_full: assert property (p_self_full) else $error("self-cal skipped full-scale step");

    property p_bg_quiet;
        @(posedge clk) disable iff (!rst_n)
        (st_q == ST_WAIT && cycle_done && kind_q == KIND_ZERO && mode == MODE_BG && !rd_data && !wr_mode)
            |=> (ready_n_q == $past(ready_n_q) && mode == MODE_BG);
    endproperty
    a_bg_quiet: assert property (p_bg_quiet) else $error("background cal cycle touched ready or mode");

endmodule : calseq_top
`default_nettype wire

// ===== calseq_core_model.sv
// filter core stand-in: answers each cycle_start with one cycle_done and a word
// assumes the sequencer's clock and reset; the bench sets the latency
`timescale 1ns/1ps
`default_nettype none
module calseq_core_model
    import calseq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cycle_start,
    input wire logic [7:0] lat,
    output logic cycle_done,
    output logic [WORD_W-1:0] cycle_word
);
    // ==========================================================
    // one cycle in flight; done never lands on the start edge
    logic busy_q;
    logic [7:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            cycle_done <= 1'b0;
            cycle_word <= '0;
        end else begin
            cycle_done <= 1'b0;
            // word is only valid with done, so it churns otherwise
            cycle_word <= ~cycle_word;
            if (cycle_start) begin
                busy_q <= 1'b1;
                cnt_q <= lat;
            end else if (busy_q && cnt_q <= 8'h01) begin
                busy_q <= 1'b0;
                cycle_done <= 1'b1;
                cycle_word <= WORD_W'($urandom);
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : calseq_core_model
`default_nettype wire

// ===== calibration_mode_sequencer_tb.sv
// self-checking bench: axi4-lite host tasks, core model, each calibration mode in turn with random fields
// assumes calseq_top and calseq_core_model on one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module calibration_mode_sequencer_tb
    import calseq_pkg::*;
;
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, lat;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic cycle_start, inputs_shorted, ref_div_gain, cycle_done, result_ready_n, irq;
    calseq_kind_t cycle_kind;
    logic [2:0] channel_sel, gain_code;
    logic [WORD_W-1:0] cycle_word, last_zero, last_full, last_conv;
    logic [5:0] exp_cg = 6'h00;
    bit sc_on = 0;
    calseq_kind_t kinds[$];
    int miscompares = 0, n_tests = 0, cycles = 0;

    calseq_top i_calseq_top (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .cycle_start(cycle_start), .cycle_kind(cycle_kind),
        .inputs_shorted(inputs_shorted), .ref_div_gain(ref_div_gain), .channel_sel(channel_sel),
        .gain_code(gain_code), .cycle_done(cycle_done), .cycle_word(cycle_word),
        .result_ready_n(result_ready_n), .irq(irq));
    calseq_core_model i_calseq_core_model (.clk(clk), .rst_n(rst_n), .cycle_start(cycle_start), .lat(lat),
        .cycle_done(cycle_done), .cycle_word(cycle_word));

    // ==========================================================
    // clock, watchdog, report
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    // ceiling sits well above the several hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ==========================================================
    // axi4-lite master
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        arvalid <= 1'b1;
        araddr <= a;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read
    task automatic sync_start;
        @(posedge clk iff cycle_start);
    endtask : sync_start

    // ==========================================================
    // core-link monitor
    always @(posedge clk) begin
        if (rst_n && cycle_done) begin
            kinds.push_back(cycle_kind);
            if (cycle_kind == KIND_ZERO) last_zero = cycle_word;
            if (cycle_kind == KIND_FULL) last_full = cycle_word;
            if (cycle_kind == KIND_CONV) last_conv = cycle_word;
            if (cycle_kind != KIND_CONV) begin
                check(inputs_shorted, cycle_kind == KIND_ZERO);
                check(ref_div_gain, cycle_kind == KIND_FULL);
                check(channel_sel, exp_cg[2:0]);
                check(gain_code, exp_cg[5:3]);
                if (sc_on) check(result_ready_n, 1'b1);
            end
        end
    end

    // ==========================================================
    // scenarios
    function automatic calseq_kind_t exp_kind(input logic [2:0] m, input int k);
        case (m)
            MODE_SELF: return (k == 0) ? KIND_ZERO : (k == 1) ? KIND_FULL : KIND_CONV;
            MODE_ZS_SELF: return (k == 0) ? KIND_ZERO : KIND_CONV;
            default: return (k == 0) ? KIND_FULL : KIND_CONV;
        endcase
    endfunction : exp_kind
    task automatic run_self(input logic [2:0] m);
        logic [31:0] d;
        logic [1:0] r;
        int i;
        exp_cg <= 6'($urandom);
        lat <= 8'($urandom_range(30, 12));
        sync_start();
        axi_write(8'h00, {23'h0, exp_cg, m}, r);
        kinds = {};
        sc_on = 1;
        i = 0;
        do begin
            axi_read(8'h00, d, r);
            i++;
        end while (d[2:0] !== MODE_NORMAL && i < 200);
        sc_on = 0;
        check(d[2:0], MODE_NORMAL);
        check(result_ready_n, 1'b0);
        check(irq, 1'b1);
        // the cycle in flight at the write still finishes as a conversion
        while (kinds.size() > 0 && kinds[0] == KIND_CONV) void'(kinds.pop_front());
        for (i = 0; i < ((m == MODE_SELF) ? 3 : 2); i++) check(kinds[i], exp_kind(m, i));
        axi_read(8'h08, d, r);
        if (m != MODE_FS_SELF) check(d, {8'h00, last_zero});
        axi_read(8'h0c, d, r);
        if (m != MODE_ZS_SELF) check(d, {8'h00, last_full});
        axi_read(8'h14, d, r);
        check(d[1], 1'b1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
    endtask : run_self
    task automatic run_bg;
        logic [31:0] d;
        logic [1:0] r;
        exp_cg <= 6'($urandom);
        lat <= 8'($urandom_range(14, 10));
        sync_start();
        axi_write(8'h00, {23'h0, exp_cg, MODE_BG}, r);
        kinds = {};
        while (kinds.size() < 20) @(posedge clk);
        while (kinds[0] == KIND_CONV) void'(kinds.pop_front());
        for (int k = 0; k < 12; k++) check(kinds[k], (k % 6 == 5) ? KIND_CONV : KIND_ZERO);
        sync_start();
        axi_read(8'h08, d, r);
        check(d, {8'h00, last_zero});
        axi_read(8'h14, d, r);
        check(d[2], 1'b1);
        axi_read(8'h00, d, r);
        check(d[8:0], {exp_cg, MODE_BG});
        do sync_start(); while (cycle_kind != KIND_ZERO);
        axi_read(8'h10, d, r);
        check(d, {8'h00, last_conv});
        @(posedge clk iff cycle_done);
        repeat (2) @(posedge clk);
        check(result_ready_n, 1'b1);
        axi_write(8'h00, {23'h0, exp_cg, MODE_NORMAL}, r);
    endtask : run_bg

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] m;
        void'($urandom(32'h6f0cea67));
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        lat = 8'h04;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        axi_read(8'h00, d, r);
        check(d, {23'h0, CTRL_RST});
        axi_read(8'h18, d, r);
        check(d, 32'h0);
        axi_write(8'h1c, 32'h1, r);
        check(r, RESP_SLVERR);
        m = 3'($urandom);
        axi_write(8'h18, {29'h0, m}, r);
        axi_read(8'h18, d, r);
        check(d, {29'h0, m});
        // only the self-cal event may interrupt, word events stay masked
        axi_write(8'h18, 32'h2, r);
        // unmapped alias of the mask index, must read zero with the mask now nonzero
        axi_read(8'h38, d, r);
        check({d, r}, {32'h0, RESP_SLVERR});
        // conversions have run since reset, so the word event is pending
        axi_read(8'h14, d, r);
        check(d[0], 1'b1);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        run_self(MODE_ZS_SELF);
        run_self(MODE_FS_SELF);
        run_self(MODE_SELF);
        run_bg();
        conclude();
    end
endmodule : calibration_mode_sequencer_tb
`default_nettype wire
